//--- interval_clock.sv
// programmable interval clock: counter, time base, modes, pulses and bus registers
//
// Behaviour
// R1: the interval counter is 16 bits and steps once per selected time-base pulse
// R2: five rates, 1 MHz down to 100 Hz, come from decade division of 10 MHz
// R3: the counter may also count line-frequency events or trigger-one firings
// R4: four modes: single, repeated, event timing, event timing from zero
// R5: overflow and trigger-one firing each give a converter start pulse
// R6: interrupts can recur at intervals set by the count and rate
// R7: each overflow drives the overflow output low about 500 ns
// R8: each trigger-one firing drives its output low like the overflow pulse
// R9: trigger events can start the counter, start conversions or interrupt
// R10: single mode loads the preset on start; overflow stops and flags
// R11: repeated mode reloads the preset on overflow and keeps running
// R12: event modes start at zero; trigger two captures count, zero variant clears it
// R13: an overflow in any mode or a trigger-two event sets overrun only when its own flag is already set
// R14: external inputs are synchronised and one edge counts one event
// R15: output pulse width is counted in base-oscillator cycles
`default_nettype none
module interval_clock
  import interval_clock_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic trigger_one_input_i,
  input wire logic trigger_two_input_i,
  input wire logic line_frequency_event_i,
  output logic overflow_pulse_out_n_o,
  output logic trigger_one_pulse_out_n_o,
  output logic irq_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ----------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] in_s1;
  logic [2:0] in_s2;
  logic [2:0] in_s3;
  logic t1_edge;
  logic t2_edge;
  logic line_edge;

  // two flops per input, third flop only for edge detection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_s1 <= 3'h0;
      in_s2 <= 3'h0;
      in_s3 <= 3'h0;
    end else begin
      in_s1 <= {line_frequency_event_i, trigger_two_input_i, trigger_one_input_i};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end
  assign t1_edge = rise(in_s3[0], in_s2[0]); // R14
  assign t2_edge = rise(in_s3[1], in_s2[1]); // R14
  assign line_edge = rise(in_s3[2], in_s2[2]); // R14 R3

  // ----------------------------------------
  // decade divider chain
  // ----------------------------------------
  logic [3:0] dec_q [DIV_STAGES];
  logic [3:0] next_dec [DIV_STAGES];
  logic [DIV_STAGES:0] carry;

  // each stage wraps at ten and passes a one-cycle enable on
  always_comb begin
    carry[0] = 1'b1;
    for (int i = 0; i < DIV_STAGES; i++) begin
      next_dec[i] = dec_q[i];
      carry[i+1] = carry[i] && (dec_q[i] == DECADE_LAST); // R2
      if (carry[i]) begin
        next_dec[i] = (dec_q[i] == DECADE_LAST) ? 4'h0 : dec_q[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < DIV_STAGES; i++) begin
        dec_q[i] <= 4'h0;
      end
    end else begin
      dec_q <= next_dec;
    end
  end

  // ----------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------
  logic bus_req;
  logic bus_write;
  logic next_wait;
  logic [31:0] next_rdata;
  logic run_q;
  mode_t mode_q;
  rate_t rate_q;
  logic go_en_q;
  logic [WIDTH-1:0] preset_q;
  logic [WIDTH-1:0] count_q;
  logic [STATUS_W-1:0] status_q;
  logic [STATUS_W-1:0] mask_q;

  assign bus_req = read_i | write_i;
  assign bus_write = write_i && !waitrequest_o;

  // drop waitrequest for one cycle after a request, with read data ready
  always_comb begin
    next_wait = !(bus_req && waitrequest_o);
    next_rdata = readdata_o;
    if (read_i && waitrequest_o) begin
      case (address_i)
        OFS_CONTROL: next_rdata = {25'h0, go_en_q, rate_q, mode_q, run_q};
        OFS_PRESET: next_rdata = {16'h0, preset_q};
        OFS_STATUS: next_rdata = {28'h0, status_q};
        OFS_MASK: next_rdata = {28'h0, mask_q};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitrequest_o <= 1'b1;
      readdata_o <= 32'h0000_0000;
    end else begin
      waitrequest_o <= next_wait;
      readdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // time base selection
  // ----------------------------------------
  logic tick;

  always_comb begin
    case (rate_q)
      RATE_1MHZ: tick = carry[1]; // R2
      RATE_100KHZ: tick = carry[2];
      RATE_10KHZ: tick = carry[3];
      RATE_1KHZ: tick = carry[4];
      RATE_100HZ: tick = carry[5];
      RATE_TRIG1: tick = t1_edge; // R3
      RATE_LINE: tick = line_edge; // R3
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter, modes and flags
  // ----------------------------------------
  logic next_run;
  mode_t next_mode;
  rate_t next_rate;
  logic next_go_en;
  logic [WIDTH-1:0] next_preset;
  logic [WIDTH-1:0] next_count;
  logic [STATUS_W-1:0] next_status;
  logic [STATUS_W-1:0] next_mask;
  logic [STATUS_W-1:0] st_set;
  logic w_ctl;
  logic start;
  logic ovf_evt;
  logic capture_evt;
  logic event_mode;

  assign w_ctl = bus_write && address_i == OFS_CONTROL && byteenable_i[0];
  assign event_mode = mode_q[1];

  always_comb begin
    next_run = run_q;
    next_mode = mode_q;
    next_rate = rate_q;
    next_go_en = go_en_q;
    next_preset = preset_q;
    next_count = count_q;
    next_mask = mask_q;
    st_set = '0;
    start = 1'b0;
    ovf_evt = 1'b0;
    capture_evt = 1'b0;
    if (w_ctl) begin
      next_mode = mode_t'(writedata_i[MODE_LSB +: 2]); // R4
      next_rate = rate_t'(writedata_i[RATE_LSB +: 3]);
      next_go_en = writedata_i[GO_EN_BIT];
      next_run = writedata_i[RUN_BIT];
      start = writedata_i[RUN_BIT] && !run_q;
    end
    if (go_en_q && t2_edge && !run_q) begin
      next_run = 1'b1; // R9
      start = 1'b1;
      st_set[ST_TRIG2] = 1'b1;
    end
    // software may not load the preset while an event mode runs
    if (bus_write && address_i == OFS_PRESET && !(event_mode && run_q)) begin
      next_preset = merge16(preset_q, writedata_i, byteenable_i);
    end
    if (bus_write && address_i == OFS_MASK) begin
      next_mask = writedata_i[STATUS_W-1:0];
    end
    if (start) begin
      next_count = next_mode[1] ? '0 : next_preset; // R10 R12
    end else if (run_q) begin
      if (tick) begin
        if (count_q == CNT_MAX) begin
          ovf_evt = 1'b1; // R5 R6
          st_set[ST_OVF] = 1'b1;
          case (mode_q)
            MODE_SINGLE: begin
              next_run = 1'b0; // R10
              next_count = '0;
            end
            MODE_REPEAT: next_count = preset_q; // R11
            default: next_count = '0;
          endcase
        end else begin
          next_count = count_q + WIDTH'(1); // R1
        end
      end
      if (event_mode && t2_edge) begin
        capture_evt = 1'b1;
        next_preset = count_q; // R12
        st_set[ST_TRIG2] = 1'b1;
        if (mode_q == MODE_EVENT_ZERO) begin
          next_count = '0; // R12
        end
      end
    end
    st_set[ST_TRIG1] = t1_edge; // R9
    st_set[ST_OVERRUN] = (st_set[ST_OVF] && status_q[ST_OVF]) || (st_set[ST_TRIG2] && status_q[ST_TRIG2]); // R13
    // write one to clear; a new event in the same cycle wins
    next_status = status_q;
    if (bus_write && address_i == OFS_STATUS) begin
      next_status = status_q & ~writedata_i[STATUS_W-1:0];
    end
    next_status = next_status | st_set;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_q <= 1'b0;
      mode_q <= MODE_SINGLE;
      rate_q <= RATE_STOP;
      go_en_q <= 1'b0;
      preset_q <= PRESET_RESET;
      count_q <= '0;
      status_q <= STATUS_RESET;
      mask_q <= STATUS_RESET;
      irq_o <= 1'b0;
    end else begin
      run_q <= next_run;
      mode_q <= next_mode;
      rate_q <= next_rate;
      go_en_q <= next_go_en;
      preset_q <= next_preset;
      count_q <= next_count;
      status_q <= next_status;
      mask_q <= next_mask;
      irq_o <= |(next_status & next_mask); // R6
    end
  end

  // ----------------------------------------
  // converter start pulses
  // ----------------------------------------
  low_pulse_gen #(.WIDTH(PULSE_CYCLES)) ovf_pulse (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .fire_i(ovf_evt), // R7 R15
    .pulse_n_o(overflow_pulse_out_n_o)
  );

  low_pulse_gen #(.WIDTH(PULSE_CYCLES)) trig1_pulse (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .fire_i(t1_edge), // R8 R15
    .pulse_n_o(trigger_one_pulse_out_n_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence ovf_low_s;
    !overflow_pulse_out_n_o [*5];
  endsequence
  sequence trig1_low_s;
    !trigger_one_pulse_out_n_o [*5];
  endsequence

  count_step_a: assert property (run_q && tick && !start && count_q != CNT_MAX && !(event_mode && t2_edge)
    |=> count_q == $past(count_q) + 16'h0001) else $error("counter did not step"); // R1
  decade_rate_a: assert property (carry[1] |=> !carry[1] [*8] ##1 !carry[1] ##1 carry[1])
    else $error("1 MHz enable not every ten cycles"); // R2
  single_stop_a: assert property (ovf_evt && mode_q == MODE_SINGLE && !w_ctl |=> !run_q && status_q[ST_OVF])
    else $error("single mode did not stop on overflow"); // R10
  repeat_reload_a: assert property (ovf_evt && mode_q == MODE_REPEAT && !w_ctl
    |=> run_q && count_q == $past(preset_q)) else $error("repeat mode did not reload"); // R11
  event_capture_a: assert property (capture_evt && !w_ctl |=> preset_q == $past(count_q) && status_q[ST_TRIG2])
    else $error("trigger two capture lost"); // R12
  zero_base_a: assert property (capture_evt && mode_q == MODE_EVENT_ZERO && !w_ctl |=> count_q == '0)
    else $error("zero-base mode did not clear counter"); // R12
  overrun_set_a: assert property (ovf_evt && status_q[ST_OVF] |=> status_q[ST_OVERRUN])
    else $error("overrun not flagged"); // R13
  ovf_pulse_a: assert property (ovf_evt |=> ovf_low_s) else $error("overflow pulse too short"); // R7
  trig1_pulse_a: assert property (t1_edge |=> trig1_low_s) else $error("trigger one pulse too short"); // R8
  irq_level_a: assert property (irq_o == |(status_q & mask_q)) else $error("interrupt level wrong"); // R6
endmodule : interval_clock
`default_nettype wire

//--- interval_clock_pkg.sv
// constants, register map and types of the programmable interval clock
`default_nettype none
package interval_clock_pkg;
  // ----------------------------------------
  // counter and time base
  // ----------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int unsigned BASE_CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DIV_STAGES = 5;
  localparam logic [3:0] DECADE_LAST = 4'h9;
  localparam int unsigned PULSE_NS = 500;
  // longest time that fits, never below one cycle
  localparam int unsigned PULSE_CYCLES = (PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (PULSE_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PRESET = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hC;

  // ----------------------------------------
  // control_status_word fields
  // ----------------------------------------
  localparam int unsigned RUN_BIT = 0;
  localparam int unsigned MODE_LSB = 1;
  localparam int unsigned RATE_LSB = 3;
  localparam int unsigned GO_EN_BIT = 6;
  localparam logic [15:0] PRESET_RESET = 16'h0000;

  // ----------------------------------------
  // status / mask fields
  // ----------------------------------------
  localparam int unsigned STATUS_W = 4;
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_TRIG2 = 1;
  localparam int unsigned ST_OVERRUN = 2;
  localparam int unsigned ST_TRIG1 = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_EVENT = 2'b10,
    MODE_EVENT_ZERO = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    RATE_STOP = 3'b000,
    RATE_1MHZ = 3'b001,
    RATE_100KHZ = 3'b010,
    RATE_10KHZ = 3'b011,
    RATE_1KHZ = 3'b100,
    RATE_100HZ = 3'b101,
    RATE_TRIG1 = 3'b110,
    RATE_LINE = 3'b111
  } rate_t;
endpackage : interval_clock_pkg
`default_nettype wire

//--- low_pulse_gen.sv
// active-low output pulse of a fixed number of clock cycles
`default_nettype none
module low_pulse_gen
  import interval_clock_pkg::*;
#(
  parameter int unsigned WIDTH = PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic fire_i,
  output logic pulse_n_o
);
  localparam int unsigned CW = $clog2(WIDTH + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // restart on each firing, else count down to idle
  always_comb begin
    if (fire_i) begin
      next_cnt = CW'(WIDTH);
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end else begin
      next_cnt = cnt;
    end
  end

  // output low while the count is running
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      pulse_n_o <= 1'b1;
    end else begin
      cnt <= next_cnt;
      pulse_n_o <= (next_cnt == '0);
    end
  end
endmodule : low_pulse_gen
`default_nettype wire

//--- event_source.sv
// far-side model: external trigger and line-frequency sources
`default_nettype none
module event_source (
  input wire logic clk_i,
  input wire logic [2:0] fire_i,
  output logic [2:0] line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left [3];
  initial begin
    line_o = 3'h0;
    for (int i = 0; i < 3; i++) begin
      left[i] = 3'h0;
    end
  end
  // each firing holds its line high four cycles, a long level that must count once
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (fire_i[i]) begin
        left[i] <= 3'h4;
      end else if (left[i] != 3'h0) begin
        left[i] <= left[i] - 3'h1;
      end
      line_o[i] <= fire_i[i] || (left[i] > 3'h1);
    end
  end
endmodule : event_source
`default_nettype wire

//--- testbench.sv
// self-checking bench of the programmable interval clock
`default_nettype none
module testbench;
  import interval_clock_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] S_OVF = 32'h0000_0001 << ST_OVF;
  localparam logic [31:0] S_TR2 = 32'h0000_0001 << ST_TRIG2;
  localparam logic [31:0] S_OVR = 32'h0000_0001 << ST_OVERRUN;
  localparam logic [31:0] S_TR1 = 32'h0000_0001 << ST_TRIG1;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] address_i = 4'h0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] byteenable_i = 4'hf;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic ovf_n;
  logic trig_n;
  logic irq_o;
  logic [2:0] fire = 3'h0;
  logic [2:0] ev;
  logic [31:0] lfsr = 32'h0000_fc10;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  always #50 clk_i = ~clk_i;
  interval_clock u_interval_clock (.clk_i(clk_i), .resetn_i(resetn_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .trigger_one_input_i(ev[0]),
    .trigger_two_input_i(ev[1]), .line_frequency_event_i(ev[2]), .overflow_pulse_out_n_o(ovf_n),
    .trigger_one_pulse_out_n_o(trig_n), .irq_o(irq_o));
  event_source u_event_source (.clk_i(clk_i), .fire_i(fire), .line_o(ev));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] r, input logic run, input logic go);
    return (32'(run) << RUN_BIT) | (32'(m) << MODE_LSB) | (32'(r) << RATE_LSB) | (32'(go) << GO_EN_BIT);
  endfunction : ctl
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask : rng
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= 4'hf;
    read_i <= rd;
    write_i <= !rd;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0000_0000);
  endtask : bus_rd
  // waits for a low pulse on one output, returns the wait, checks its width
  task automatic wait_low(input logic sel, input int lim, output int w);
    int k;
    w = 0;
    k = 0;
    while ((sel ? trig_n : ovf_n) !== 1'b0 && w < lim) begin
      @(posedge clk_i);
      w++;
    end
    while ((sel ? trig_n : ovf_n) === 1'b0 && k < 9) begin
      @(posedge clk_i);
      k++;
    end
    chk(32'(k), 32'(PULSE_CYCLES));
  endtask : wait_low
  task automatic pulse_in(input logic [2:0] b);
    @(posedge clk_i);
    fire <= b;
    @(posedge clk_i);
    fire <= 3'h0;
    repeat (8) @(posedge clk_i);
  endtask : pulse_in
  // compares each read answer with the oldest noted expectation
  always @(posedge clk_i) begin
    if (read_i && waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      chk(readdata_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus_rd(OFS_CONTROL, 32'h0000_0000);
    bus_rd(OFS_STATUS, 32'h0000_0000);
    bus_rd(4'h2, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      bus_wr(OFS_PRESET, lfsr);
      bus_rd(OFS_PRESET, {16'h0000, lfsr[15:0]});
    end
    // single interval: sixteen 1 MHz ticks, then stop and flag
    bus_wr(OFS_MASK, 32'h0000_000f);
    bus_wr(OFS_PRESET, 32'h0000_fff0);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_1MHZ, 1'b1, 1'b0));
    wait_low(1'b0, 400, n);
    rng(n, 150, 175);
    chk(irq_o, 1'b1);
    bus_rd(OFS_CONTROL, ctl(MODE_SINGLE, RATE_1MHZ, 1'b0, 1'b0));
    bus_rd(OFS_STATUS, S_OVF);
    bus_wr(OFS_STATUS, S_OVF);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    // repeated interval: reload, keep running, second flag gives overrun
    bus_wr(OFS_PRESET, 32'h0000_fffe);
    bus_wr(OFS_CONTROL, ctl(MODE_REPEAT, RATE_1MHZ, 1'b1, 1'b0));
    wait_low(1'b0, 100, n);
    wait_low(1'b0, 100, n);
    rng(n, 12, 18);
    bus_rd(OFS_CONTROL, ctl(MODE_REPEAT, RATE_1MHZ, 1'b1, 1'b0));
    bus_rd(OFS_STATUS, S_OVF | S_OVR);
    bus_wr(OFS_CONTROL, 32'h0000_0000);
    bus_wr(OFS_STATUS, 32'h0000_000f);
    // event timing: capture, refused preset write, zero-base capture
    bus_wr(OFS_CONTROL, ctl(MODE_EVENT, RATE_1MHZ, 1'b1, 1'b0));
    bus_wr(OFS_PRESET, 32'h0000_1234);
    bus_rd(OFS_PRESET, 32'h0000_fffe);
    repeat (100) @(posedge clk_i);
    pulse_in(3'h2);
    bus_rd(OFS_STATUS, S_TR2);
    rng(int'(readdata_o[31:16]), 0, 0);
    // upper half of the captured word must read zero
    bus_rd(OFS_PRESET, 32'h0000_0000, 32'hffff_0000);
    rng(int'(readdata_o[15:0]), 8, 14);
    bus_wr(OFS_CONTROL, ctl(MODE_EVENT_ZERO, RATE_1MHZ, 1'b1, 1'b0));
    pulse_in(3'h2);
    repeat (50) @(posedge clk_i);
    pulse_in(3'h2);
    bus_rd(OFS_PRESET, 32'h0000_0000, 32'hffff_0000);
    rng(int'(readdata_o[15:0]), 5, 7);
    bus_rd(OFS_STATUS, S_TR2 | S_OVR);
    bus_wr(OFS_CONTROL, 32'h0000_0000);
    bus_wr(OFS_STATUS, 32'h0000_000f);
    // trigger one: output pulse, masked then unmasked interrupt
    bus_wr(OFS_MASK, 32'h0000_0000);
    pulse_in(3'h1);
    chk(irq_o, 1'b0);
    bus_rd(OFS_STATUS, S_TR1);
    bus_wr(OFS_MASK, S_TR1);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    bus_wr(OFS_STATUS, S_TR1);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    fork
      wait_low(1'b1, 20, n);
      pulse_in(3'h1);
    join
    rng(n, 1, 6);
    // counting trigger-one firings and line events, one count per long level
    bus_wr(OFS_STATUS, 32'h0000_000f);
    bus_wr(OFS_PRESET, 32'h0000_fffd);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_TRIG1, 1'b1, 1'b0));
    pulse_in(3'h1);
    pulse_in(3'h1);
    bus_rd(OFS_STATUS, 32'h0000_0000, S_OVF);
    fork
      wait_low(1'b0, 30, n);
      pulse_in(3'h1);
    join
    rng(n, 1, 12);
    bus_wr(OFS_STATUS, 32'h0000_000f);
    bus_wr(OFS_PRESET, 32'h0000_fffe);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_LINE, 1'b1, 1'b0));
    pulse_in(3'h4);
    bus_rd(OFS_STATUS, 32'h0000_0000);
    pulse_in(3'h4);
    bus_rd(OFS_STATUS, S_OVF);
    // trigger two starts the counter when enabled
    bus_wr(OFS_STATUS, 32'h0000_000f);
    bus_wr(OFS_PRESET, 32'h0000_fff0);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_1MHZ, 1'b0, 1'b1));
    pulse_in(3'h2);
    bus_rd(OFS_CONTROL, ctl(MODE_SINGLE, RATE_1MHZ, 1'b1, 1'b1));
    wait_low(1'b0, 200, n);
    rng(n, 130, 165);
    bus_rd(OFS_STATUS, S_TR2 | S_OVF);
    // decade rates: two ticks end in one overflow
    for (int r = 1; r <= 4; r++) begin
      bus_wr(OFS_STATUS, 32'h0000_000f);
      bus_wr(OFS_PRESET, 32'h0000_fffe);
      bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, 3'(r), 1'b1, 1'b0));
      wait_low(1'b0, 2 * (10 ** r) + 20, n);
      rng(n, 10 ** r - 5, 2 * (10 ** r) + 5);
    end
    bus_wr(OFS_STATUS, 32'h0000_000f);
    bus_wr(OFS_PRESET, 32'h0000_ffff);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_STOP, 1'b1, 1'b0));
    repeat (30) @(posedge clk_i);
    bus_rd(OFS_STATUS, 32'h0000_0000);
    bus_wr(OFS_CONTROL, ctl(MODE_SINGLE, RATE_100HZ, 1'b0, 1'b0));
    bus_rd(OFS_CONTROL, ctl(MODE_SINGLE, RATE_100HZ, 1'b0, 1'b0));
    complete_run();
  end
endmodule : testbench
`default_nettype wire
